// *** common/split_timer_pkg.sv ***
package split_timer_pkg;

    // register indices; byte address = 4*index
    localparam logic [5:0] REG_RUN_CTRL   = 6'h00;
    localparam logic [5:0] REG_PIN_EN     = 6'h01;
    localparam logic [5:0] REG_IDLE_VAL   = 6'h02;
    localparam logic [5:0] REG_SPLIT_CTRL = 6'h03;
    localparam logic [5:0] REG_CMD_CLR    = 6'h04;
    localparam logic [5:0] REG_CMD_SET    = 6'h05;
    localparam logic [5:0] REG_INT_EN     = 6'h0a;
    localparam logic [5:0] REG_INT_FLAGS  = 6'h0b;
    localparam logic [5:0] REG_LOWER_CNT  = 6'h20;
    localparam logic [5:0] REG_UPPER_CNT  = 6'h21;
    localparam logic [5:0] REG_LOWER_TOP  = 6'h26;
    localparam logic [5:0] REG_UPPER_TOP  = 6'h27;
    localparam logic [5:0] REG_LOWER_CMP0 = 6'h28;
    localparam logic [5:0] REG_UPPER_CMP0 = 6'h29;
    localparam logic [5:0] REG_WAVE_MODE  = 6'h30;
    localparam logic [5:0] REG_IRQ_STATUS = 6'h31;

    // field positions
    localparam int RUN_BIT      = 0;
    localparam int DIV_LSB      = 1;
    localparam int CMDTGT_LSB   = 0;
    localparam int CMD_LSB      = 2;
    localparam int UPPER_LSB    = 4;
    localparam int LOWER_LSB    = 0;
    localparam int CMPF_LSB     = 4;
    localparam int UUNF_BIT     = 1;
    localparam int LOWER_UNDERFLOW_BIT     = 0;

    // reset values and masks
    localparam logic [7:0] TOP_RESET   = 8'hff;
    localparam logic [7:0] CTRL_RESET  = 8'h00;
    localparam logic [7:0] PIN_MASK    = 8'h77;
    localparam logic [7:0] RUN_MASK    = 8'h0f;
    localparam logic [7:0] FLAG_MASK   = 8'h73;

    // command and target codes
    localparam logic [1:0] CMD_NONE    = 2'h0;
    localparam logic [1:0] CMD_RESTART = 2'h2;
    localparam logic [1:0] CMD_HARD    = 2'h3;
    localparam logic [1:0] TGT_BOTH    = 2'h3;

    // wave modes: 0 none (idle levels), 1 frequency, 2 pulse width
    localparam logic [1:0] WAVE_FRQ    = 2'h1;
    localparam logic [1:0] WAVE_PWM    = 2'h2;

    localparam int CHANNELS = 3;
    localparam int PRESC_W  = 10;

    // one avalon request as the slave latches it
    typedef struct packed {
        logic [5:0] index;
        logic       write;
        logic [7:0] data;
    } bus_req_s;

    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_DO   = 3'b010,
        BUS_ACK  = 3'b100
    } bus_state_e;

endpackage : split_timer_pkg

// *** rtl/split_timer.sv ***
`timescale 1ns/100ps
//Function
// - tick divider field bits 3:1 divides clock by 1,2,4,8,16,64,256,1024
// - counters run only while run bit 0 is set
// - upper pin enable n lets waveform drive upper output n in wave modes
// - lower pin enable n lets waveform drive lower output n in wave modes
// - while stopped, upper idle level n sets upper output n value
// - while stopped, lower idle level n sets lower output n value
// - pad sees value only when enabled; custom logic path bypasses enables
// - dual counter select bit 0 makes two independent 8-bit counters
// - clear alias: ones clear control bits, zeros leave them
// - set alias: ones set control bits, zeros leave them
// - command field: none, reserved, restart, hard reset; reads zero
// - hard reset ignored while running
// - target field 3 selects both counters, 0 none, others reserved
// - interrupt requested per enabled source flag
// - lower compare flag n set when lower count equals compare n
// - lower compare flags stay set until software writes one
// - upper underflow flag set when upper count reaches zero, only while dual counter select is set
// - lower underflow flag set when lower count reaches zero
// - underflow flags stay set until software writes one
// - lower top value register resets to all ones
// - upper top value register resets to all ones
// - lower compares continuously checked and drive waveforms
module split_timer
    import split_timer_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rstn,
    // avalon-mm slave
    input  wire logic [7:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    // waveform outputs to pads, with enables (low while driving)
    output logic      [2:0]  padLower,
    output logic      [2:0]  padLowerOen,
    output logic      [2:0]  padUpper,
    output logic      [2:0]  padUpperOen,
    // waveform outputs to custom logic, enables bypassed
    output logic      [5:0]  logicWave,
    // interrupt request lines, one per source
    output logic      [7:0]  irqLines
);

    ////////////////////////////////////////////////////////////////////////
    // registers and state
    logic [7:0] runCtrl;
    logic [7:0] pinEn;
    logic [7:0] idleVal;
    logic       dualSel;
    logic [1:0] cmdTarget;
    logic [7:0] intEn;
    logic [7:0] interrupt_flags;
    logic [1:0] waveMode;
    logic [7:0] lowerCnt;
    logic [7:0] upperCnt;
    logic [7:0] lowerTop;
    logic [7:0] upperTop;
    logic [7:0] lowerCmp [CHANNELS];
    logic [7:0] upperCmp [CHANNELS];
    logic [2:0] lowerWave;
    logic [2:0] upperWave;
    logic [PRESC_W-1:0] presc;
    bus_state_e busState;
    bus_req_s   req;

    logic       running;
    logic       tick;
    logic       wrStb;
    logic       doRestart;
    logic       doHard;
    logic [1:0] cmdCode;
    logic [2:0] lowerHit;
    logic [7:0] next_flags;

    // divider ratio minus one as a mask of prescaler bits
    function automatic logic [PRESC_W-1:0] div_mask(input logic [2:0] sel);
        unique case (sel)
            3'h0: div_mask = 10'h000;
            3'h1: div_mask = 10'h001;
            3'h2: div_mask = 10'h003;
            3'h3: div_mask = 10'h007;
            3'h4: div_mask = 10'h00f;
            3'h5: div_mask = 10'h03f;
            3'h6: div_mask = 10'h0ff;
            3'h7: div_mask = 10'h3ff;
        endcase
    endfunction : div_mask

    assign running = runCtrl[RUN_BIT];
    // writes land in the answer cycle, at the edge where the master sees waitrequest low
    assign wrStb   = (busState == BUS_ACK) && req.write;

    ////////////////////////////////////////////////////////////////////////
    // bus slave: latch request, read one cycle later, then drop waitrequest as any write lands
    always_ff @(posedge clock) begin
        if (!rstn) begin
            busState <= BUS_IDLE;
            req      <= '0;
        end else begin
            unique case (busState)
                BUS_IDLE: begin
                    if (read || write) begin
                        req.index <= address[7:2];
                        req.write <= write;
                        req.data  <= writedata[7:0];
                        busState  <= BUS_DO;
                    end
                end
                BUS_DO:  busState <= BUS_ACK;
                BUS_ACK: busState <= BUS_IDLE;
                default: busState <= BUS_IDLE;
            endcase
        end
    end

    // waitrequest stays high except in the answering cycle
    always_ff @(posedge clock) begin
        if (!rstn) begin
            waitrequest <= 1'b1;
        end else begin
            waitrequest <= !(busState == BUS_DO);
        end
    end

    // read mux; unmapped offsets read zero, command field always reads zero
    always_ff @(posedge clock) begin
        if (!rstn) begin
            readdata <= '0;
        end else if (busState == BUS_DO && !req.write) begin
            readdata <= '0;
            unique case (req.index)
                REG_RUN_CTRL:   readdata[7:0] <= runCtrl & RUN_MASK;
                REG_PIN_EN:     readdata[7:0] <= pinEn;
                REG_IDLE_VAL:   readdata[7:0] <= idleVal;
                REG_SPLIT_CTRL: readdata[7:0] <= {7'h00, dualSel};
                REG_CMD_CLR,
                REG_CMD_SET:    readdata[7:0] <= {6'h00, cmdTarget};
                REG_INT_EN:     readdata[7:0] <= intEn;
                REG_INT_FLAGS:  readdata[7:0] <= interrupt_flags;
                REG_LOWER_CNT:  readdata[7:0] <= lowerCnt;
                REG_UPPER_CNT:  readdata[7:0] <= upperCnt;
                REG_LOWER_TOP:  readdata[7:0] <= lowerTop;
                REG_UPPER_TOP:  readdata[7:0] <= upperTop;
                REG_WAVE_MODE:  readdata[7:0] <= {6'h00, waveMode};
                REG_IRQ_STATUS: readdata[7:0] <= interrupt_flags & intEn;
                default: begin
                    for (int i = 0; i < CHANNELS; i++) begin
                        if (req.index == REG_LOWER_CMP0 + 6'(2 * i)) begin
                            readdata[7:0] <= lowerCmp[i];
                        end
                        if (req.index == REG_UPPER_CMP0 + 6'(2 * i)) begin
                            readdata[7:0] <= upperCmp[i];
                        end
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration registers
    always_ff @(posedge clock) begin
        if (!rstn) begin
            runCtrl  <= CTRL_RESET;
            pinEn    <= CTRL_RESET;
            idleVal  <= CTRL_RESET;
            dualSel  <= 1'b0;
            intEn    <= CTRL_RESET;
            waveMode <= 2'h0;
            lowerTop <= TOP_RESET;
            upperTop <= TOP_RESET;
            for (int i = 0; i < CHANNELS; i++) begin
                lowerCmp[i] <= 8'h00;
                upperCmp[i] <= 8'h00;
            end
        end else if (wrStb) begin
            unique case (req.index)
                REG_RUN_CTRL:   runCtrl  <= req.data & RUN_MASK;
                REG_PIN_EN:     pinEn    <= req.data & PIN_MASK;
                REG_IDLE_VAL:   idleVal  <= req.data & PIN_MASK;
                REG_SPLIT_CTRL: dualSel  <= req.data[0];
                REG_INT_EN:     intEn    <= req.data & FLAG_MASK;
                REG_LOWER_TOP:  lowerTop <= req.data;
                REG_UPPER_TOP:  upperTop <= req.data;
                REG_WAVE_MODE:  waveMode <= req.data[1:0];
                default: begin
                    for (int i = 0; i < CHANNELS; i++) begin
                        if (req.index == REG_LOWER_CMP0 + 6'(2 * i)) begin
                            lowerCmp[i] <= req.data;
                        end
                        if (req.index == REG_UPPER_CMP0 + 6'(2 * i)) begin
                            upperCmp[i] <= req.data;
                        end
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command aliases; target bits persist, command is a one-shot
    assign cmdCode = (wrStb && req.index == REG_CMD_SET)
                   ? req.data[CMD_LSB +: 2] : CMD_NONE;
    // reserved target codes select no counter
    assign doRestart = (cmdCode == CMD_RESTART) && (cmdTarget == TGT_BOTH);
    // hard reset dropped while running; needs both counters selected
    assign doHard = (cmdCode == CMD_HARD) && (cmdTarget == TGT_BOTH)
                  && !running;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            cmdTarget <= 2'h0;
        end else if (wrStb && req.index == REG_CMD_CLR) begin
            cmdTarget <= cmdTarget & ~req.data[CMDTGT_LSB +: 2];
        end else if (wrStb && req.index == REG_CMD_SET) begin
            cmdTarget <= cmdTarget | req.data[CMDTGT_LSB +: 2];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // prescaler; counts while running, cleared while stopped or on restart; tick when masked bits are all ones
    always_ff @(posedge clock) begin
        if (!rstn || !running || doRestart) begin
            presc <= '0;
        end else begin
            presc <= presc + 1'b1;
        end
    end

    assign tick = running && ((presc & div_mask(runCtrl[DIV_LSB +: 3]))
                == div_mask(runCtrl[DIV_LSB +: 3]));

    ////////////////////////////////////////////////////////////////////////
    // counters: bus write wins over counting; down count with reload
    always_ff @(posedge clock) begin
        if (!rstn || doHard || doRestart) begin
            lowerCnt <= 8'h00;
        end else if (wrStb && req.index == REG_LOWER_CNT) begin
            lowerCnt <= req.data;
        end else if (tick) begin
            lowerCnt <= (lowerCnt == 8'h00) ? lowerTop : lowerCnt - 8'h01;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn || doHard || doRestart) begin
            upperCnt <= 8'h00;
        end else if (wrStb && req.index == REG_UPPER_CNT) begin
            upperCnt <= req.data;
        end else if (tick && dualSel) begin
            upperCnt <= (upperCnt == 8'h00) ? upperTop : upperCnt - 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // flags: hardware set wins over software one-write clear
    always_comb begin
        for (int i = 0; i < CHANNELS; i++) begin
            lowerHit[i] = (lowerCnt == lowerCmp[i]);
        end
        next_flags = interrupt_flags;
        if (wrStb && req.index == REG_INT_FLAGS) begin
            next_flags = interrupt_flags & ~req.data;
        end
        if (tick) begin
            next_flags[CMPF_LSB +: 3] = next_flags[CMPF_LSB +: 3] | lowerHit;
            if (lowerCnt == 8'h00) begin
                next_flags[LOWER_UNDERFLOW_BIT] = 1'b1;
            end
            if (dualSel && upperCnt == 8'h00) begin
                next_flags[UUNF_BIT] = 1'b1;
            end
        end
        next_flags = next_flags & FLAG_MASK;
    end

    always_ff @(posedge clock) begin
        if (!rstn || doHard) begin
            interrupt_flags <= 8'h00;
        end else begin
            interrupt_flags <= next_flags;
        end
    end

    // one request line per enabled source
    always_ff @(posedge clock) begin
        if (!rstn) begin
            irqLines <= 8'h00;
        end else begin
            irqLines <= interrupt_flags & intEn;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // waveform generators; idle levels load while stopped
    always_ff @(posedge clock) begin
        if (!rstn) begin
            lowerWave <= 3'h0;
            upperWave <= 3'h0;
        end else if (!running) begin
            lowerWave <= idleVal[LOWER_LSB +: 3];
            upperWave <= idleVal[UPPER_LSB +: 3];
        end else if (doRestart) begin
            lowerWave <= 3'h0;
            upperWave <= 3'h0;
        end else if (tick) begin
            for (int i = 0; i < CHANNELS; i++) begin
                if (waveMode == WAVE_FRQ && lowerHit[i]) begin
                    lowerWave[i] <= ~lowerWave[i];
                end else if (waveMode == WAVE_PWM) begin
                    lowerWave[i] <= (lowerCnt <= lowerCmp[i]);
                end
                if (waveMode == WAVE_FRQ && upperCnt == upperCmp[i]) begin
                    upperWave[i] <= ~upperWave[i];
                end else if (waveMode == WAVE_PWM) begin
                    upperWave[i] <= (upperCnt <= upperCmp[i]);
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output stage; pads gated by enables, logic path not
    always_ff @(posedge clock) begin
        if (!rstn) begin
            padLower    <= 3'h0;
            padUpper    <= 3'h0;
            padLowerOen <= 3'h7;
            padUpperOen <= 3'h7;
            logicWave   <= 6'h00;
        end else begin
            padLower    <= lowerWave;
            padUpper    <= upperWave;
            padLowerOen <= ~pinEn[LOWER_LSB +: 3];
            padUpperOen <= ~pinEn[UPPER_LSB +: 3];
            logicWave   <= {upperWave, lowerWave};
        end
    end

endmodule : split_timer

// *** verification/split_timer_assertions.sv ***
`timescale 1ns/100ps
module split_timer_assertions
    import split_timer_pkg::*;
(
    // clock and reset
    input wire logic        clock,
    input wire logic        rstn,
    // avalon-mm slave
    input wire logic [7:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    // waveform and request outputs
    input wire logic [2:0]  padLower,
    input wire logic [2:0]  padLowerOen,
    input wire logic [2:0]  padUpper,
    input wire logic [2:0]  padUpperOen,
    input wire logic [5:0]  logicWave,
    input wire logic [7:0]  irqLines
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    logic       wrAcc;
    logic       runShadow;
    logic [7:0] pinShadow;
    logic [7:0] idleShadow;
    logic [1:0] quiet;

    // a write lands where waitrequest is seen low
    assign wrAcc = write && !waitrequest;

    // shadows of config bytes
    always_ff @(posedge clock) begin
        if (!rstn) begin
            runShadow  <= 1'b0;
            pinShadow  <= 8'h00;
            idleShadow <= 8'h00;
        end else if (wrAcc) begin
            if (address[7:2] == REG_RUN_CTRL) runShadow <= writedata[RUN_BIT];
            if (address[7:2] == REG_PIN_EN) pinShadow <= writedata[7:0];
            if (address[7:2] == REG_IDLE_VAL) idleShadow <= writedata[7:0];
        end
    end

    // cycles since last write; outputs lag a few
    always_ff @(posedge clock) begin
        if (!rstn || wrAcc) begin
            quiet <= 2'd0;
        end else if (quiet != 2'd3) begin
            quiet <= quiet + 2'd1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    a_wait_two_cycles: assert property ($rose(read || write) |-> waitrequest ##1 waitrequest
        ##1 !waitrequest) else $error("answer not two cycles late");
    a_wait_one_cycle: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low too long");
    a_answer_needs_request: assert property (!waitrequest |-> (read || write))
        else $error("answer without a request");
    a_readdata_upper_zero: assert property (readdata[31:8] == 24'h0)
        else $error("readdata upper bits not zero");
    a_pin_enable_follows: assert property (
        (wrAcc && address[7:2] == REG_PIN_EN) |-> ##2 (padLowerOen == ~pinShadow[2:0])
        && (padUpperOen == ~pinShadow[6:4])) else $error("pad enables do not follow");
    a_irq_reserved_low: assert property ((irqLines & ~FLAG_MASK) == 8'h00)
        else $error("request on a reserved bit");
    a_flags_sticky_set: assert property (
        (|($past(irqLines) & ~irqLines)) |-> ($past(wrAcc) || $past(wrAcc, 2)
        || $past(wrAcc, 3))) else $error("request dropped without a write");
    a_idle_wave_level: assert property ((quiet == 2'd3 && !runShadow) |->
        logicWave == {idleShadow[6:4], idleShadow[2:0]}) else $error("idle level lost");
    a_idle_pad_level: assert property ((quiet == 2'd3 && !runShadow) |->
        ((padLower ^ idleShadow[2:0]) & ~padLowerOen) == 3'h0
        && ((padUpper ^ idleShadow[6:4]) & ~padUpperOen) == 3'h0)
        else $error("pad differs from idle level");

    // main scenarios seen
    c_write_done: cover property (wrAcc);
    c_read_done: cover property (read && !waitrequest);
    c_irq_raised: cover property (irqLines != 8'h00);
endmodule : split_timer_assertions

bind split_timer split_timer_assertions checks (.*);

// *** verification/wave_pad_model.sv ***
`timescale 1ns/100ps
module wave_pad_model (
    // clock
    input  wire logic       clock,
    // pad drivers, enables low while driving
    input  wire logic [2:0] padLower,
    input  wire logic [2:0] padLowerOen,
    input  wire logic [2:0] padUpper,
    input  wire logic [2:0] padUpperOen,
    // resolved pad levels, upper above lower
    output logic      [5:0] pinLevel
);
    logic [5:0] lastLevel;

    // no keeper on these pads: a released one flips each cycle
    always_ff @(posedge clock) begin
        lastLevel <= pinLevel;
    end

    // the pad carries the value only while its enable is low
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            pinLevel[i]     = padLowerOen[i] ? ~lastLevel[i] : padLower[i];
            pinLevel[i + 3] = padUpperOen[i] ? ~lastLevel[i + 3] : padUpper[i];
        end
    end
endmodule : wave_pad_model

// *** verification/dual_8bit_split_timer_control_bench.sv ***
`timescale 1ns/100ps
module dual_8bit_split_timer_control_bench;
    import split_timer_pkg::*;
    // bus side
    logic        clock;
    logic        rstn;
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [31:0] readdata;
    logic        waitrequest;
    // pad and custom logic side
    logic [2:0]  padLower;
    logic [2:0]  padLowerOen;
    logic [2:0]  padUpper;
    logic [2:0]  padUpperOen;
    logic [5:0]  logicWave;
    logic [7:0]  irqLines;
    logic [5:0]  pinLevel;
    // bookkeeping
    int          fails;
    int          comparisons;
    logic [7:0]  rdByte;

    split_timer dut (.*);
    wave_pad_model pads (.*);

    // 100 mhz clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // one transfer, held until waitrequest is seen low; next call waits an edge
    task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] data);
        int n;
        n = 0;
        @(posedge clock);
        address   <= {idx, 2'b00};
        writedata <= {24'h0, data};
        write     <= wr;
        read      <= !wr;
        @(posedge clock);
        while (waitrequest !== 1'b0 && n < 20) begin
            @(posedge clock);
            n++;
        end
        if (n == 20) begin
            fails++;
            $display("ERROR waitrequest expected 0 seen %b", waitrequest);
        end
        rdByte = readdata[7:0];
        write  <= 1'b0;
        read   <= 1'b0;
    endtask : bus

    task automatic rd(input logic [5:0] idx);
        bus(1'b0, idx, 8'h00);
    endtask : rd

    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] seen);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check8

    // tick counts get a window: prescaler phase is loose
    task automatic check_range(input string what, input int lo, input int hi,
                               input logic [8:0] seen);
        comparisons++;
        if ((seen >= 9'(lo) && seen <= 9'(hi)) !== 1'b1) begin
            fails++;
            $display("ERROR %s expected %0d..%0d seen %0d", what, lo, hi, seen);
        end
    endtask : check_range

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_reset_values;
        logic [5:0] idx [0:10];
        logic [7:0] exp [0:10];
        idx = '{REG_RUN_CTRL, REG_PIN_EN, REG_IDLE_VAL, REG_SPLIT_CTRL, REG_CMD_CLR,
                REG_CMD_SET, REG_INT_EN, REG_INT_FLAGS, REG_LOWER_TOP, REG_UPPER_TOP, 6'h10};
        exp = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                TOP_RESET, TOP_RESET, 8'h00};
        bus(1'b1, 6'h10, 8'hff);
        foreach (idx[i]) begin
            rd(idx[i]);
            check8("reset value", exp[i], rdByte);
        end
        check8("pads released", 8'h07, {5'h0, padLowerOen});
        $display("test reset_values done");
    endtask : test_reset_values

    task automatic test_aliases;
        bus(1'b1, REG_CMD_SET, 8'h03);
        rd(REG_CMD_CLR);
        check8("target set", 8'h03, rdByte);
        bus(1'b1, REG_CMD_CLR, 8'h01);
        rd(REG_CMD_SET);
        check8("target cleared", 8'h02, rdByte);
        bus(1'b1, REG_CMD_SET, 8'h0d);
        rd(REG_CMD_SET);
        check8("command field", 8'h03, rdByte);
        bus(1'b1, REG_CMD_CLR, 8'h0c);
        rd(REG_CMD_CLR);
        check8("zeros leave bits", 8'h03, rdByte);
        $display("test aliases done");
    endtask : test_aliases

    task automatic test_idle_levels;
        bus(1'b1, REG_IDLE_VAL, 8'h35);
        bus(1'b1, REG_PIN_EN, 8'h61);
        repeat (3) @(posedge clock);
        check8("custom logic wave", 8'h1d, {2'h0, logicWave});
        check8("lower enables", 8'h06, {5'h0, padLowerOen});
        check8("upper enables", 8'h01, {5'h0, padUpperOen});
        check8("driven pads", 8'h11, {2'h0, pinLevel & 6'h31});
        $display("test idle_levels done");
    endtask : test_idle_levels

    task automatic test_waveform;
        bus(1'b1, REG_IDLE_VAL, 8'h00);
        bus(1'b1, REG_PIN_EN, 8'h11);
        bus(1'b1, REG_WAVE_MODE, {6'h0, WAVE_PWM});
        bus(1'b1, REG_SPLIT_CTRL, 8'h01);
        bus(1'b1, REG_LOWER_CMP0, 8'hff);
        bus(1'b1, REG_UPPER_CMP0, 8'hff);
        bus(1'b1, REG_RUN_CTRL, 8'h03);
        repeat (4) @(posedge clock);
        check8("pwm wave", 8'h09, {2'h0, logicWave & 6'h09});
        check8("pwm pads", 8'h09, {2'h0, pinLevel & 6'h09});
        bus(1'b1, REG_RUN_CTRL, 8'h00);
        repeat (3) @(posedge clock);
        check8("stopped wave", 8'h00, {2'h0, logicWave});
        $display("test waveform done");
    endtask : test_waveform

    task automatic test_flags;
        bus(1'b1, REG_LOWER_TOP, 8'h04);
        bus(1'b1, REG_UPPER_TOP, 8'h03);
        bus(1'b1, REG_LOWER_CMP0, 8'h01);
        bus(1'b1, 6'h2a, 8'h02);
        bus(1'b1, 6'h2c, 8'h03);
        bus(1'b1, REG_CMD_SET, {4'h0, CMD_RESTART, TGT_BOTH});
        bus(1'b1, REG_RUN_CTRL, 8'h01);
        rd(REG_LOWER_CNT);
        bus(1'b1, REG_RUN_CTRL, 8'h00);
        rd(REG_INT_FLAGS);
        check8("flags after run", 8'h73, rdByte);
        check8("no request", 8'h00, irqLines);
        bus(1'b1, REG_INT_EN, 8'h12);
        repeat (2) @(posedge clock);
        check8("masked requests", 8'h12, irqLines);
        bus(1'b1, REG_INT_FLAGS, 8'h01);
        rd(REG_INT_FLAGS);
        check8("one flag cleared", 8'h72, rdByte);
        bus(1'b1, REG_INT_FLAGS, 8'h70);
        rd(REG_INT_FLAGS);
        check8("compare flags cleared", 8'h02, rdByte);
        check8("upper request", 8'h02, irqLines);
        $display("test flags done");
    endtask : test_flags

    task automatic test_divider;
        int         divs [0:7];
        logic [8:0] ticks;
        logic [7:0] held;
        divs = '{1, 2, 4, 8, 16, 64, 256, 1024};
        bus(1'b1, REG_LOWER_TOP, 8'hff);
        for (int k = 0; k < 8; k++) begin
            bus(1'b1, REG_CMD_SET, 8'h0b);
            rd(REG_LOWER_CNT);
            check8("count after restart", 8'h00, rdByte);
            bus(1'b1, REG_RUN_CTRL, {4'h0, k[2:0], 1'b1});
            repeat (4 * divs[k]) @(posedge clock);
            bus(1'b1, REG_RUN_CTRL, 8'h00);
            rd(REG_LOWER_CNT);
            ticks = (rdByte == 8'h00) ? 9'h000 : 9'h100 - {1'b0, rdByte};
            check_range("ticks", 3, 5 + 8 / divs[k], ticks);
        end
        held = rdByte;
        repeat (20) @(posedge clock);
        rd(REG_LOWER_CNT);
        check8("count held", held, rdByte);
        $display("test divider done");
    endtask : test_divider

    task automatic test_commands;
        logic [8:0] ticks;
        bus(1'b1, REG_CMD_SET, 8'h0b);
        bus(1'b1, REG_RUN_CTRL, 8'h01);
        bus(1'b1, REG_CMD_SET, 8'h0f);
        bus(1'b1, REG_RUN_CTRL, 8'h00);
        rd(REG_LOWER_CNT);
        ticks = (rdByte == 8'h00) ? 9'h000 : 9'h100 - {1'b0, rdByte};
        check_range("ticks past hard reset", 7, 10, ticks);
        bus(1'b1, REG_CMD_SET, 8'h0f);
        rd(REG_LOWER_CNT);
        check8("hard reset count", 8'h00, rdByte);
        rd(REG_INT_FLAGS);
        check8("hard reset flags", 8'h00, rdByte);
        $display("test commands done");
    endtask : test_commands

    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop

    // the divider sweep dominates at about 5.7k cycles
    initial begin
        repeat (30000) @(posedge clock);
        fails++;
        $display("ERROR watchdog expected finish seen timeout");
        report_and_stop();
    end

    // stimulus starts quiet; reset is held four cycles
    initial begin
        rstn        = 1'b0;
        address     = 8'h00;
        read        = 1'b0;
        write       = 1'b0;
        writedata   = 32'h0;
        fails       = 0;
        comparisons = 0;
        repeat (4) @(posedge clock);
        rstn <= 1'b1;
        test_reset_values();
        test_aliases();
        test_idle_levels();
        test_waveform();
        test_flags();
        test_divider();
        test_commands();
        report_and_stop();
    end
endmodule : dual_8bit_split_timer_control_bench
